// ---- pfbfe_defs.svh ----
// Purpose: Build-time defaults and fixed figures of the polyphase filter front end.
// Assumes: Included by bare name after the package is compiled.
// Notes:   Definitions only, guarded against double inclusion.
`ifndef PFBFE_DEFS_SVH
`define PFBFE_DEFS_SVH

// ****************************************
// Default geometry and widths
// ****************************************
`define PFBFE_PFB_SIZE    3
`define PFBFE_N_IN_LOG    1
`define PFBFE_TAPS        4
`define PFBFE_IN_W        8
`define PFBFE_OUT_W       12
`define PFBFE_COEF_W      8
`define PFBFE_LUTRAM      1

// ****************************************
// Default latencies and scaling
// ****************************************
`define PFBFE_ADD_LAT     1
`define PFBFE_MULT_LAT    2
`define PFBFE_BRAM_LAT    2
`define PFBFE_FWIDTH_Q8   256
`define PFBFE_FW_ONE_Q8   256

// ****************************************
// Fixed-point and buffer figures
// ****************************************
`define PFBFE_Q15_ONE     32767
`define PFBFE_HAMM_A_Q15  17694
`define PFBFE_HAMM_B_PCT  46
`define PFBFE_PI_NUM      355
`define PFBFE_PI_DEN      113
`define PFBFE_FIFO_DEPTH  4

`endif

// ---- pfbfe_pkg.sv ----
// Purpose: Types shared by the polyphase filter front end.
// Assumes: Compiled before every other file of the block.
// Notes:   Only enumerations live here; figures sit in the header.
`default_nettype none

package pfbfe_pkg;

	// ****************************************
	// Selectable options
	// ****************************************
	// Window shapes applied to the sinc prototype.
	typedef enum {PFBFE_WIN_RECT, PFBFE_WIN_HANN, PFBFE_WIN_HAMMING, PFBFE_WIN_TRI} pfbfe_win_t;

	// Ways of returning a wide sum to the output width.
	typedef enum {PFBFE_Q_TRUNC, PFBFE_Q_ROUND_UP, PFBFE_Q_ROUND_EVEN} pfbfe_quant_t;

endpackage : pfbfe_pkg

`default_nettype wire

// ---- pfbfe_fifo.sv ----
// Purpose: Small synchronous FIFO between the filter and the transform.
// Assumes: One clock; writes and reads use valid and ready.
// Notes:   Read data come straight from the storage flops.
`timescale 1ns/1ns
`default_nettype none
`include "pfbfe_defs.svh"

module pfbfe_fifo
	import pfbfe_pkg::*;
#(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = `PFBFE_FIFO_DEPTH
)(
	// Clock and reset.
	input  wire logic         i_sys_clk,
	input  wire logic         i_arst_n,
	// Write side.
	input  wire logic         i_wr_valid,
	output logic             o_wr_ready,
	input  wire logic [W-1:0] i_wr_data,
	// Read side.
	output logic             o_rd_valid,
	input  wire logic         i_rd_ready,
	output logic [W-1:0]     o_rd_data
);

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [W-1:0] mem_r   [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          wr, rd;

	// Honest full and empty flags from the word count.
	assign o_wr_ready = (cnt_r != FULL);
	assign o_rd_valid = (cnt_r != '0);
	assign o_rd_data  = mem_r[rp_r];
	assign wr         = i_wr_valid & o_wr_ready;
	assign rd         = o_rd_valid & i_rd_ready;

	// Pointer, count and storage updates.
	always_comb begin
		mem_nxt = mem_r;
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		if (wr) begin
			mem_nxt[wp_r] = i_wr_data;
			wp_nxt        = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
		end
		if (rd) begin
			rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
		end
		cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
	end

	// Registers only.
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mem_r <= '{default: '0};
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// A word is never written into a full buffer.
	a_fifo_no_overflow : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(cnt_r == FULL) |=> (cnt_r <= FULL))
		else $error("fifo count exceeded its depth");

endmodule : pfbfe_fifo

`default_nettype wire

// ---- pfbfe_core.sv ----
// Purpose: Polyphase FIR front end feeding a transform of equal length.
// Assumes: Source holds lanes steady while valid is high and not taken.
// Notes:   The pipeline moves only when an input word is taken.
//
// Operation
// - Output marker leads first output by one clock.
// - Power-of-two lanes in, as many out, or twice as many with dual-stream.
// - Channels are two to size; taps buffer.
// - Tap count fixed by parameter at build.
// - Window shape selectable among several functions.
// - Dual-stream option duplicates lanes at output.
// - Input sample width set by parameter.
// - Output sample width set by parameter.
// - Coefficient width configurable, like input width.
// - Coefficients in LUT or registered block RAM.
// - Selectable rounding back to output width.
// - Bin-width scale widens or narrows channels.
// - Adder, multiplier, RAM latencies set total delay.
// - Real or complex input; output stays time-domain.
`timescale 1ns/1ns
`default_nettype none
`include "pfbfe_defs.svh"

module pfbfe_core
	import pfbfe_pkg::*;
#(
	parameter int unsigned  PFB_SIZE  = `PFBFE_PFB_SIZE,
	parameter int unsigned  N_IN_LOG  = `PFBFE_N_IN_LOG,
	parameter int unsigned  TAPS      = `PFBFE_TAPS,
	parameter int unsigned  IN_W      = `PFBFE_IN_W,
	parameter int unsigned  OUT_W     = `PFBFE_OUT_W,
	parameter int unsigned  COEF_W    = `PFBFE_COEF_W,
	parameter int unsigned  COEF_IN_LUTRAM = `PFBFE_LUTRAM,
	parameter int unsigned  ADD_LAT   = `PFBFE_ADD_LAT,
	parameter int unsigned  MULT_LAT  = `PFBFE_MULT_LAT,
	parameter int unsigned  BRAM_LAT  = `PFBFE_BRAM_LAT,
	parameter int unsigned  FWIDTH_Q8 = `PFBFE_FWIDTH_Q8,
	parameter bit           COMPLEX   = 1'b1,
	parameter bit           BIPLEX    = 1'b0,
	parameter pfbfe_win_t   WINDOW    = PFBFE_WIN_HAMMING,
	parameter pfbfe_quant_t QUANT     = PFBFE_Q_ROUND_EVEN,
	localparam int unsigned NL = 2**N_IN_LOG,
	localparam int unsigned NO = BIPLEX ? 2*NL : NL
)(
	// Clock and reset.
	input  wire logic              i_sys_clk,
	input  wire logic              i_arst_n,
	// Sample stream from the source.
	input  wire logic              i_in_sync,
	input  wire logic              i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [NL*IN_W-1:0] i_in_re,
	input  wire logic [NL*IN_W-1:0] i_in_im,
	// Filtered stream to the transform.
	output logic                  o_out_sync,
	output logic                  o_out_valid,
	input  wire logic              i_out_ready,
	output logic [NO*OUT_W-1:0]   o_out_re,
	output logic [NO*OUT_W-1:0]   o_out_im
);

	// ****************************************
	// Derived geometry
	// ****************************************
	localparam int unsigned NCH = 2**PFB_SIZE;
	localparam int unsigned D   = NCH / NL;
	localparam int unsigned M   = TAPS * NCH;
	localparam int unsigned PHW = (D > 1) ? $clog2(D) : 1;
	localparam int unsigned HL  = (TAPS - 1) * D;
	localparam int unsigned HLN = (HL > 0) ? HL : 1;
	localparam int unsigned PW  = IN_W + COEF_W;
	localparam int unsigned SW  = PW + $clog2(TAPS + 1);
	localparam int unsigned SH  = PW - 1 - OUT_W;
	localparam int unsigned CL  = (COEF_IN_LUTRAM == 1) ? 0 : BRAM_LAT;
	localparam int unsigned PD  = CL + MULT_LAT + ADD_LAT * $clog2(TAPS);
	localparam int unsigned PDN = (PD > 0) ? PD : 1;
	localparam int unsigned DW  = 2 + 2 * NL * SW;
	localparam int unsigned FW  = 1 + 2 * NL * OUT_W;
	localparam logic [PHW-1:0]     PH_LAST = PHW'(D - 1);
	localparam logic signed [SW:0] QMAX = (SW+1)'(2**(OUT_W-1) - 1);
	localparam logic signed [SW:0] QMIN = -QMAX - 1;
	localparam logic [SW-1:0]      LOWM = (SW'(1) << (SH - 1)) - 1'b1;

	// ****************************************
	// Build-time and datapath arithmetic
	// ****************************************
	// Integer sine in Q15 for phase p of a full turn of per steps.
	function automatic longint pfbfe_sin(input longint p, input longint per);
		longint h, x, a, v;
		h = per / 2;
		x = p % h;
		a = x * (h - x);
		v = (`PFBFE_Q15_ONE * 16 * a) / (5 * h * h - 4 * a);
		return (p >= h) ? -v : v;
	endfunction : pfbfe_sin

	// Windowed sinc prototype value for coefficient k.
	function automatic logic signed [COEF_W-1:0] pfbfe_coef(input int k);
		longint per, u, s, snc, per2, cs, w, c;
		per  = 4 * NCH * `PFBFE_FW_ONE_Q8;
		// Signed throughout: an unsigned geometry term would turn negative offsets into huge ones.
		u    = (longint'(2 * k + 1) - longint'(M)) * longint'(FWIDTH_Q8);
		s    = pfbfe_sin(((u % per) + per) % per, per);
		snc  = (s * 2 * longint'(NCH) * `PFBFE_FW_ONE_Q8 * `PFBFE_PI_DEN) / (`PFBFE_PI_NUM * u);
		per2 = (M > 1) ? 4 * (M - 1) : 4;
		cs   = pfbfe_sin((4 * k + M - 1) % per2, per2);
		case (WINDOW)
			PFBFE_WIN_HANN:    w = (`PFBFE_Q15_ONE - cs) / 2;
			PFBFE_WIN_HAMMING: w = `PFBFE_HAMM_A_Q15 - (cs * `PFBFE_HAMM_B_PCT) / 100;
			PFBFE_WIN_TRI:     w = (M > 1) ? `PFBFE_Q15_ONE - (`PFBFE_Q15_ONE
			                   * ((2 * k > M - 1) ? 2 * k - M + 1 : M - 1 - 2 * k)) / (M - 1)
			                   : `PFBFE_Q15_ONE;
			default:           w = `PFBFE_Q15_ONE;
		endcase
		c = (snc * w) / `PFBFE_Q15_ONE;
		c = (c * ((longint'(1) <<< (COEF_W - 1)) - 1)) / `PFBFE_Q15_ONE;
		return COEF_W'(c);
	endfunction : pfbfe_coef

	// Table index of lane l, tap t at phase ph; oldest tap takes the first row.
	function automatic int pfbfe_idx(input int l, input int t, input logic [PHW-1:0] ph);
		return (TAPS - 1 - t) * NCH + int'(ph) * NL + l;
	endfunction : pfbfe_idx

	// Return a wide sum to the output width with rounding and saturation.
	function automatic logic signed [OUT_W-1:0] pfbfe_quant(input logic signed [SW-1:0] a);
		logic signed [SW:0] r;
		logic               up;
		r = $signed({a[SW-1], a}) >>> SH;
		case (QUANT)
			PFBFE_Q_ROUND_UP:   up = a[SH-1];
			PFBFE_Q_ROUND_EVEN: up = a[SH-1] & (((a & LOWM) != '0) | r[0]);
			default:            up = 1'b0;
		endcase
		r = r + $signed({{SW{1'b0}}, up});
		if (r > QMAX) r = QMAX;
		if (r < QMIN) r = QMIN;
		return r[OUT_W-1:0];
	endfunction : pfbfe_quant

	// ****************************************
	// Coefficient storage
	// ****************************************
	logic signed [COEF_W-1:0] coef_tab [M];
	logic signed [COEF_W-1:0] coef     [NL][TAPS];
	logic [PHW-1:0]           ph_r, ph_nxt;

	// Constant table, folded at elaboration.
	for (genvar g = 0; g < M; g++) begin : g_tab
		assign coef_tab[g] = pfbfe_coef(g);
	end

	if (COEF_IN_LUTRAM == 1) begin : g_lut
		// Distributed storage answers in the same cycle.
		always_comb begin
			for (int l = 0; l < NL; l++) begin
				for (int t = 0; t < TAPS; t++) begin
					coef[l][t] = coef_tab[pfbfe_idx(l, t, ph_r)];
				end
			end
		end
	end else begin : g_bram
		logic signed [COEF_W-1:0] crd_r [NL][TAPS];
		logic signed [COEF_W-1:0] crd_nxt [NL][TAPS];
		// Block storage reads one cycle ahead using the next word's phase.
		always_comb begin
			for (int l = 0; l < NL; l++) begin
				for (int t = 0; t < TAPS; t++) begin
					crd_nxt[l][t] = coef_tab[pfbfe_idx(l, t, ph_nxt)];
				end
			end
		end
		always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				crd_r <= '{default: '0};
			end else begin
				crd_r <= crd_nxt;
			end
		end
		assign coef = crd_r;
	end

	// ****************************************
	// Frame alignment and tap history
	// ****************************************
	logic                   adv, pend_r, pend_nxt, f_ready, f_valid;
	logic signed [IN_W-1:0] x_re [NL];
	logic signed [IN_W-1:0] x_im [NL];
	logic signed [IN_W-1:0] h_re_r [NL][HLN];
	logic signed [IN_W-1:0] h_im_r [NL][HLN];
	logic signed [IN_W-1:0] h_re_nxt [NL][HLN];
	logic signed [IN_W-1:0] h_im_nxt [NL][HLN];

	// The whole pipeline steps when a word is taken.
	assign adv = i_in_valid & o_in_ready;

	// Lane samples; the real variant feeds zero imaginary parts.
	always_comb begin
		for (int l = 0; l < NL; l++) begin
			x_re[l] = $signed(i_in_re[l*IN_W +: IN_W]);
			x_im[l] = COMPLEX ? $signed(i_in_im[l*IN_W +: IN_W]) : '0;
		end
	end

	// Marker pending, phase of the next word, and history shift.
	always_comb begin
		pend_nxt = pend_r;
		ph_nxt   = ph_r;
		h_re_nxt = h_re_r;
		h_im_nxt = h_im_r;
		if (adv) begin
			pend_nxt = 1'b0;
			ph_nxt   = (ph_r == PH_LAST) ? '0 : ph_r + 1'b1;
			for (int l = 0; l < NL; l++) begin
				h_re_nxt[l][0] = x_re[l];
				h_im_nxt[l][0] = x_im[l];
				for (int k = 1; k < HLN; k++) begin
					h_re_nxt[l][k] = h_re_r[l][k-1];
					h_im_nxt[l][k] = h_im_r[l][k-1];
				end
			end
		end
		// A new marker wins over the clearing take.
		if (i_in_sync) begin
			pend_nxt = 1'b1;
			ph_nxt   = '0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend_r <= 1'b0;
			ph_r   <= '0;
			h_re_r <= '{default: '0};
			h_im_r <= '{default: '0};
		end else begin
			pend_r <= pend_nxt;
			ph_r   <= ph_nxt;
			h_re_r <= h_re_nxt;
			h_im_r <= h_im_nxt;
		end
	end

	// ****************************************
	// Multiply, sum, delay and round
	// ****************************************
	logic signed [SW-1:0] s_re [NL];
	logic signed [SW-1:0] s_im [NL];
	logic signed [IN_W-1:0] tr, ti;
	logic [DW-1:0] head, tail;
	logic [DW-1:0] pipe_r [PDN];
	logic [DW-1:0] pipe_nxt [PDN];
	logic [FW-1:0] q_r, q_nxt;
	logic          qv_r, qv_nxt;

	// Each tap weights one sample of its lane.
	always_comb begin
		tr = '0;
		ti = '0;
		for (int l = 0; l < NL; l++) begin
			s_re[l] = '0;
			s_im[l] = '0;
			for (int t = 0; t < TAPS; t++) begin
				tr = (t == 0) ? x_re[l] : h_re_r[l][t*D-1];
				ti = (t == 0) ? x_im[l] : h_im_r[l][t*D-1];
				// Operands widened first so the product keeps all of its bits.
				s_re[l] = s_re[l] + SW'(PW'(tr) * PW'(coef[l][t]));
				s_im[l] = s_im[l] + SW'(PW'(ti) * PW'(coef[l][t]));
			end
			head[2 + 2*l*SW +: SW]      = s_re[l];
			head[2 + (2*l+1)*SW +: SW]  = s_im[l];
		end
		head[1:0] = {1'b1, pend_r};
	end

	// Delay line standing for the configured stage latencies.
	always_comb begin
		pipe_nxt = pipe_r;
		if (adv) begin
			pipe_nxt[0] = head;
			for (int i = 1; i < PDN; i++) begin
				pipe_nxt[i] = pipe_r[i-1];
			end
		end
		tail = (PD == 0) ? head : pipe_r[PDN-1];
		q_nxt  = q_r;
		qv_nxt = qv_r;
		if (adv) begin
			qv_nxt = tail[1];
			q_nxt[0] = tail[0];
			for (int l = 0; l < NL; l++) begin
				q_nxt[1 + 2*l*OUT_W +: OUT_W]     = pfbfe_quant(tail[2 + 2*l*SW +: SW]);
				q_nxt[1 + (2*l+1)*OUT_W +: OUT_W] = pfbfe_quant(tail[2 + (2*l+1)*SW +: SW]);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pipe_r <= '{default: '0};
			q_r    <= '0;
			qv_r   <= 1'b0;
		end else begin
			pipe_r <= pipe_nxt;
			q_r    <= q_nxt;
			qv_r   <= qv_nxt;
		end
	end

	// ****************************************
	// Output buffer and frame marker
	// ****************************************
	logic [FW-1:0] f_data;
	logic          shown_r, shown_nxt, lead;
	logic          wr_ready;

	pfbfe_fifo #(
		.W     (FW),
		.DEPTH (`PFBFE_FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk  (i_sys_clk),
		.i_arst_n   (i_arst_n),
		.i_wr_valid (adv & qv_r),
		.o_wr_ready (wr_ready),
		.i_wr_data  (q_r),
		.o_rd_valid (f_valid),
		.i_rd_ready (f_ready),
		.o_rd_data  (f_data)
	);

	// A full buffer stalls the source and the whole pipeline.
	assign o_in_ready = wr_ready;

	// A frame's first word is held back one cycle behind its marker.
	assign lead        = f_valid & f_data[0] & ~shown_r;
	assign o_out_sync  = lead;
	assign o_out_valid = f_valid & ~lead;
	assign f_ready     = o_out_valid & i_out_ready;

	always_comb begin
		shown_nxt = shown_r;
		if (lead) shown_nxt = 1'b1;
		if (f_ready) shown_nxt = 1'b0;
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shown_r <= 1'b0;
		end else begin
			shown_r <= shown_nxt;
		end
	end

	// Lanes leave unchanged, twice over for a dual-stream transform.
	for (genvar o = 0; o < NO; o++) begin : g_out
		assign o_out_re[o*OUT_W +: OUT_W] = f_data[1 + 2*(o%NL)*OUT_W +: OUT_W];
		assign o_out_im[o*OUT_W +: OUT_W] = f_data[1 + (2*(o%NL)+1)*OUT_W +: OUT_W];
	end

	// ****************************************
	// Checks
	// ****************************************
	a_sync_leads_data : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_out_sync |=> o_out_valid && f_data[0])
		else $error("output marker not followed by first word");

	a_sync_single : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_out_sync |=> !o_out_sync)
		else $error("output marker lasted more than one cycle");

	a_phase_restart : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_in_sync |=> (ph_r == '0) && pend_r)
		else $error("input marker did not restart the phase");

	a_phase_wrap : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(adv && !i_in_sync && ph_r == PH_LAST) |=> (ph_r == '0))
		else $error("phase did not wrap after the last channel group");

	a_stall_holds : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(!adv && !i_in_sync) |=> $stable(ph_r) && $stable(qv_r) && $stable(q_r))
		else $error("pipeline moved without a taken word");

	a_out_held : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(o_out_valid && !i_out_ready) |=> o_out_valid && $stable(o_out_re) && $stable(o_out_im))
		else $error("output word changed before it was taken");

	a_dual_copy : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		BIPLEX |-> (o_out_re[NO*OUT_W-1 -: OUT_W] == o_out_re[NL*OUT_W-1 -: OUT_W]))
		else $error("duplicated lanes differ");

	a_real_zero : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(!COMPLEX && o_out_valid) |-> (o_out_im == '0))
		else $error("real variant carried an imaginary part");

endmodule : pfbfe_core

`default_nettype wire

// ---- pfbfe_fft_sink.sv ----
// Purpose: Behavioural model of the transform that takes the filtered stream.
// Assumes: One clock; ready moves a fixed delay after the rising edge.
// Notes:   Counts words, frame markers and marker slips for the bench.
`timescale 1ns/1ns
`default_nettype none

module pfbfe_fft_sink #(
	parameter int unsigned W = 24
)(
	// Clock, reset and stall mode: 0 ready, 1 stalled, 2 alternating.
	input  wire logic         i_sys_clk,
	input  wire logic         i_arst_n,
	input  wire logic [1:0]   i_mode,
	// Stream from the filter.
	input  wire logic         i_out_sync,
	input  wire logic         i_out_valid,
	output logic             o_out_ready,
	input  wire logic [W-1:0] i_out_re,
	input  wire logic [W-1:0] i_out_im,
	// Tallies for the bench.
	output int               o_taken,
	output int               o_syncs,
	output int               o_sync_err,
	output int               o_nonzero
);
	logic sync_seen_r;

	// Ready changes just after each edge, never at it.
	initial o_out_ready = 1'b1;
	always @(posedge i_sys_clk) begin
		#10;
		case (i_mode)
			2'h0: o_out_ready = 1'b1;
			2'h1: o_out_ready = 1'b0;
			default: o_out_ready = ~o_out_ready;
		endcase
	end

	// Tallies are taken at the edge where a word or a marker is sampled.
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_taken <= 0;
			o_syncs <= 0;
			o_sync_err <= 0;
			o_nonzero <= 0;
			sync_seen_r <= 1'b0;
		end else begin
			sync_seen_r <= i_out_sync;
			if (i_out_valid && o_out_ready) begin
				o_taken <= o_taken + 1;
				if ((i_out_re !== '0) || (i_out_im !== '0)) o_nonzero <= o_nonzero + 1;
			end
			// A marker stands alone and the next cycle carries the first word.
			if ((i_out_sync && (i_out_valid !== 1'b0)) || (sync_seen_r && (i_out_valid !== 1'b1))) begin
				o_sync_err <= o_sync_err + 1;
			end
			if (i_out_sync) o_syncs <= o_syncs + 1;
		end
	end
endmodule : pfbfe_fft_sink

`default_nettype wire

// ---- pfbfe_core_tb.sv ----
// Purpose: Self-checking bench of the filter front end.
// Assumes: Default geometry; coefficients in LUT memory, so no load cycle.
// Notes:   Zero real samples keep expected data exact without a coefficient model.
//          The real variant is built, so the nonzero imaginary lanes offered must be dropped.
`timescale 1ns/1ns
`default_nettype none

module pfbfe_core_tb
	import pfbfe_pkg::*;
;
	localparam int NL    = 2;
	localparam int IN_W  = 8;
	localparam int OUT_W = 12;
	localparam int TAPS  = 4;
	localparam int DEPTH = 4;
	localparam int PD    = 2 + 1 * $clog2(TAPS);

	logic                 clk;
	logic                 rst_n;
	logic                 in_sync;
	logic                 in_valid;
	logic                 in_ready;
	logic [NL*IN_W-1:0]   in_re;
	logic [NL*IN_W-1:0]   in_im;
	logic                 out_sync;
	logic                 out_valid;
	logic                 out_ready;
	logic [NL*OUT_W-1:0]  out_re;
	logic [NL*OUT_W-1:0]  out_im;
	logic [1:0]           sink_mode;
	int                   taken;
	int                   syncs;
	int                   sync_err;
	int                   nonzero;
	int                   bad_count;
	int                   num_checks;
	int                   t;

	pfbfe_core #(.N_IN_LOG(1), .TAPS(TAPS), .IN_W(IN_W), .OUT_W(OUT_W), .COEF_IN_LUTRAM(1),
		.ADD_LAT(1), .MULT_LAT(2), .COMPLEX(1'b0)) dut (
		.i_sys_clk(clk), .i_arst_n(rst_n), .i_in_sync(in_sync), .i_in_valid(in_valid),
		.o_in_ready(in_ready), .i_in_re(in_re), .i_in_im(in_im), .o_out_sync(out_sync),
		.o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_re(out_re), .o_out_im(out_im));

	pfbfe_fft_sink #(.W(NL*OUT_W)) sink (
		.i_sys_clk(clk), .i_arst_n(rst_n), .i_mode(sink_mode), .i_out_sync(out_sync),
		.i_out_valid(out_valid), .o_out_ready(out_ready), .i_out_re(out_re), .i_out_im(out_im),
		.o_taken(taken), .o_syncs(syncs), .o_sync_err(sync_err), .o_nonzero(nonzero));

	// A 100 ns clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	// Compares counts.
	task automatic check_n(string what, int exp, int got);
		num_checks++;
		if (exp !== got) begin
			bad_count++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_n

	// Compares single design flags, so an unknown never matches.
	task automatic check_b(string what, logic exp, logic got);
		num_checks++;
		if (exp !== got) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask : check_b

	// Holds reset three edges, then leaves one idle edge after release.
	task automatic do_reset(logic [1:0] mode);
		rst_n = 1'b0;
		in_sync = 1'b0;
		in_valid = 1'b0;
		sink_mode = mode;
		repeat (3) @(posedge clk);
		#10;
		check_b("ready in reset", 1'b1, in_ready);
		check_b("valid in reset", 1'b0, out_valid);
		check_b("sync in reset", 1'b0, out_sync);
		rst_n = 1'b1;
		@(posedge clk);
		#10;
	endtask : do_reset

	// Frame marker one cycle ahead of the first word.
	task automatic send_sync();
		in_sync = 1'b1;
		@(posedge clk);
		#10;
		in_sync = 1'b0;
	endtask : send_sync

	// Offers zero real words and nonzero imaginary ones until n of them are taken.
	task automatic send_words(int n);
		int got;
		got = 0;
		in_re = '0;
		in_im = 16'h3c5a;
		in_valid = 1'b1;
		for (int c = 0; c < 400 && got < n; c++) begin
			// Ready is settled here and holds until the coming edge takes the word.
			if (in_ready === 1'b1) got++;
			@(posedge clk);
			#10;
		end
		in_valid = 1'b0;
		if (got < n) begin
			check_n("words taken", n, got);
			tally_and_finish();
		end
	endtask : send_words

	// Waits until the sink has taken n words, then lets the stream settle.
	task automatic wait_out(int n);
		for (int c = 0; c < 200 && taken < n; c++) @(posedge clk);
		if (taken < n) begin
			check_n("words drained", n, taken);
			tally_and_finish();
		end
		repeat (10) @(posedge clk);
		#10;
	endtask : wait_out

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		bad_count = 0;
		num_checks = 0;
		in_re = '0;
		in_im = '0;
		rst_n = 1'b0;
		in_sync = 1'b0;
		in_valid = 1'b0;
		sink_mode = 2'h0;
		#10;
		check_n("lane width", NL * OUT_W, $bits(out_re));
		// Back-to-back stream: outputs trail inputs by the pipeline depth plus the output register.
		do_reset(2'h0);
		send_sync();
		send_words(13);
		wait_out(13 - PD - 1);
		check_n("words out", 13 - PD - 1, taken);
		check_n("markers out", 1, syncs);
		check_n("marker slips", 0, sync_err);
		check_n("nonzero words", 0, nonzero);
		// Stalled transform: the buffer fills, refuses, then drains.
		do_reset(2'h1);
		send_sync();
		in_valid = 1'b1;
		t = 0;
		// Ready is read where it is settled; each pass lets one taking edge go by.
		for (int c = 0; c < 20 && in_ready === 1'b1; c++) begin
			t++;
			@(posedge clk);
			#10;
		end
		check_n("takes until full", PD + 1 + DEPTH, t);
		repeat (3) @(posedge clk);
		#10;
		check_b("ready while full", 1'b0, in_ready);
		in_valid = 1'b0;
		sink_mode = 2'h0;
		wait_out(DEPTH);
		check_n("drained words", DEPTH, taken);
		check_b("valid when empty", 1'b0, out_valid);
		check_b("ready when empty", 1'b1, in_ready);
		check_n("marker slips stalled", 0, sync_err);
		// Two frames against a transform that takes every other cycle.
		do_reset(2'h2);
		send_sync();
		send_words(4);
		send_sync();
		send_words(12);
		wait_out(16 - PD - 1);
		check_n("words two frames", 16 - PD - 1, taken);
		check_n("markers two frames", 2, syncs);
		check_n("slips two frames", 0, sync_err);
		check_n("nonzero two frames", 0, nonzero);
		tally_and_finish();
	end
endmodule : pfbfe_core_tb

`default_nettype wire
